// ==== design/pin_mode_control.sv ====
/*
 * pin-mode decode, trim (self-calibration) start and AHB-Lite register slave.
 * assumes pins synchronous to CLOCK_IN and a single AHB-Lite master.
 */
// Design decisions made here: the AHB-Lite slave port and the register addresses.
// Overview of operation
// R1: trim starts after request low for minimum, then high for minimum.
// R2: request high at power-on suppresses power-on trim until low-then-high.
// R3: extended mode request is pin OR control bit 15.
// R4: host drives pin and bit low, then raises either one.
// R5: delay-select high gives longer power-on wait, low gives shorter.
// R6: trim_in_progress high exactly while a trim sequence runs.
// R7: outside extended mode, phase pin low gives 0 deg, high 90 deg.
// R8: phase selection acts only in split (1:2) output mode.
// R9: extended mode takes phase from control bit 14, default 0 deg.
// R10: outside extended mode, interleave pin high samples in-phase on both channels.
// R11: extended mode takes interleave from control bit 7, default independent.
// R12: independent mode: each channel converts its own input.
// R13: interleaved converts in-phase; extended bit 6 may choose quadrature.
// R14: pin sets common range; extended mode uses per-channel range registers.
// R15: pin high maps to mid range, pin low to minimum range.
// R16: offset adjustment allowed only in extended mode.
// R17: level-select pin high chooses higher output common mode.
// R18: coupling pin low chooses AC coupling, else DC coupling.
// R19: DC coupling disables internal input bias on both channels.
// R20: enable_n low gives extended mode; high resets all registers.
// R21: unsplit pin low gives 1:2 output, high gives 1:1.
// R22: request edges detected on registered pin values.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mode_cfg.svh"
module pin_mode_control #(
    parameter int POR_SHORT_CYC = `CYC_RNDUP(`POR_SHORT_NS),
    parameter int POR_LONG_CYC  = `CYC_RNDUP(`POR_LONG_NS),
    parameter int TRIM_RUN_CYC  = `CYC_RNDUP(`TRIM_RUN_NS)
) (
    // clock and reset
    input  wire logic                 CLOCK_IN,
    input  wire logic                 SYS_RST_IN,
    // control pins
    input  wire pin_mode_pkg::pins_t  PINS_IN,
    // decoded modes
    output logic                      TRIM_IN_PROGRESS_OUT,
    output pin_mode_pkg::mode_t       MODE_OUT,
    output logic [12:0]               OFFSET_OUT,
    // ahb-lite slave
    input  wire logic                 HSEL_IN,
    input  wire logic [31:0]          HADDR_IN,
    input  wire logic [1:0]           HTRANS_IN,
    input  wire logic                 HWRITE_IN,
    input  wire logic [2:0]           HSIZE_IN,
    input  wire logic [31:0]          HWDATA_IN,
    input  wire logic                 HREADY_IN,
    output logic                      HREADYOUT_OUT,
    output logic                      HRESP_OUT,
    output logic [31:0]               HRDATA_OUT
);
    import pin_mode_pkg::*;

    localparam int LOW_MIN_CYC  = `CYC_RNDUP(`PIN_LOW_MIN_NS);
    localparam int HIGH_MIN_CYC = `CYC_RNDUP(`PIN_HIGH_MIN_NS);

    state_t s_r;
    state_t s_nxt;

    logic        ext_mode;
    logic        eff_req;
    logic        trim_go;
    logic [15:0] por_target;

    // =================================================================
    // pin and mode decode
    always_comb begin
        // R20 extended mode select
        ext_mode = ~PINS_IN.extended_control_enable_n;
        // R3 effective request
        eff_req  = PINS_IN.trim_request | (ext_mode & s_r.ctl[`CTL_TRIM_BIT]);
        // R5 power-on wait select
        por_target = PINS_IN.trim_start_delay_select ? 16'(POR_LONG_CYC) : 16'(POR_SHORT_CYC);
    end

    // =================================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        trim_go = 1'b0;
        s_nxt.req_prev = eff_req;

        // R22 low and high qualification on registered request
        // qualifying the registered copy keeps the counters off a pin that moves mid-cycle
        if (!s_r.req_prev) begin
            s_nxt.high_cnt = 16'h0000;
            if (s_r.low_cnt != 16'(LOW_MIN_CYC)) begin
                s_nxt.low_cnt = s_r.low_cnt + 16'h0001;
            end else begin
                s_nxt.seen_low = 1'b1;
            end
        end else begin
            s_nxt.low_cnt = 16'h0000;
            if (s_r.seen_low) begin
                if (s_r.high_cnt != 16'(HIGH_MIN_CYC)) begin
                    s_nxt.high_cnt = s_r.high_cnt + 16'h0001;
                end else begin
                    // R1 qualified low-then-high
                    trim_go = 1'b1;
                    s_nxt.seen_low = 1'b0;
                    s_nxt.high_cnt = 16'h0000;
                end
            end
        end

        // R2 catch request level on the first cycle after reset
        if (s_r.por_armed) begin
            s_nxt.por_armed = 1'b0;
            s_nxt.inhibit   = eff_req;
            s_nxt.seen_low  = 1'b0;
        end

        unique case (s_r.state)
            ST_POR_WAIT: begin
                // R2 request held high at power-on inhibits
                if (s_r.inhibit) begin
                    if (trim_go) begin
                        s_nxt.inhibit = 1'b0;
                        s_nxt.state   = ST_RUN;
                        s_nxt.run_cnt = 16'h0000;
                    end
                end else if (s_r.wait_cnt >= por_target) begin
                    s_nxt.state   = ST_RUN;
                    s_nxt.run_cnt = 16'h0000;
                end else begin
                    s_nxt.wait_cnt = s_r.wait_cnt + 16'h0001;
                end
            end
            ST_IDLE: begin
                if (trim_go) begin
                    s_nxt.state   = ST_RUN;
                    s_nxt.run_cnt = 16'h0000;
                end
            end
            ST_RUN: begin
                if (s_r.run_cnt == 16'(TRIM_RUN_CYC - 1)) begin
                    s_nxt.state = ST_IDLE;
                    s_nxt.trim_count = s_r.trim_count + 16'h0001;
                end else begin
                    s_nxt.run_cnt = s_r.run_cnt + 16'h0001;
                end
            end
        endcase
        // R6 run flag registered from state
        s_nxt.trim_run = (s_nxt.state == ST_RUN);

        // ahb-lite data phase
        s_nxt.hready = 1'b1;
        if (s_r.dp_active && s_r.dp_write && ext_mode) begin
            unique case (s_r.dp_addr)
                `REG_CONTROL_ADDR: s_nxt.ctl     = HWDATA_IN;
                `REG_RANGE_I_ADDR: s_nxt.range_i = HWDATA_IN[1:0];
                `REG_RANGE_Q_ADDR: s_nxt.range_q = HWDATA_IN[1:0];
                `REG_OFFSET_ADDR:  s_nxt.offset  = HWDATA_IN[12:0];
                default: ;
            endcase
        end
        s_nxt.dp_active = HSEL_IN & HREADY_IN & HTRANS_IN[1];
        s_nxt.dp_write  = HWRITE_IN;
        s_nxt.dp_addr   = HADDR_IN[7:0];
        s_nxt.rdata     = 32'h0000_0000;
        if (HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN) begin
            unique case (HADDR_IN[7:0])
                `REG_CONTROL_ADDR: s_nxt.rdata = s_nxt.ctl;
                `REG_RANGE_I_ADDR: s_nxt.rdata = {30'h0, s_nxt.range_i};
                `REG_RANGE_Q_ADDR: s_nxt.rdata = {30'h0, s_nxt.range_q};
                `REG_OFFSET_ADDR:  s_nxt.rdata = {19'h0, s_nxt.offset};
                `REG_STATUS_ADDR:  s_nxt.rdata = {s_r.trim_count, 13'h0, s_r.inhibit, ext_mode, s_r.trim_run};
                default:           s_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // R20 registers return to defaults outside extended mode
        if (!ext_mode) begin
            s_nxt.ctl     = `CTL_RESET_VAL;
            s_nxt.range_i = `RANGE_RESET_VAL;
            s_nxt.range_q = `RANGE_RESET_VAL;
            s_nxt.offset  = `OFFSET_RESET_VAL;
        end

        // R12 R10 R11 sampling mode
        s_nxt.mode.interleaved = ext_mode ? s_nxt.ctl[`CTL_INTERLEAVE_BIT] : PINS_IN.interleave_select;
        // R13 input choice in interleaved mode
        s_nxt.mode.convert_quadrature = s_nxt.mode.interleaved & ext_mode & s_nxt.ctl[`CTL_SECOND_IN_BIT];
        // R21 output split select
        s_nxt.mode.unsplit_output = PINS_IN.unsplit_output_select;
        // R7 R8 R9 phase only in split mode
        s_nxt.mode.phase_90 = ~PINS_IN.unsplit_output_select &
            (ext_mode ? s_nxt.ctl[`CTL_PHASE_BIT] : PINS_IN.output_clock_phase_select);
        // R14 R15 range source and mapping
        if (ext_mode) begin
            s_nxt.mode.range_i = s_nxt.range_i;
            s_nxt.mode.range_q = s_nxt.range_q;
        end else begin
            s_nxt.mode.range_i = PINS_IN.input_range_select ? `RANGE_MID : `RANGE_MIN;
            s_nxt.mode.range_q = PINS_IN.input_range_select ? `RANGE_MID : `RANGE_MIN;
        end
        // R17 common-mode level
        s_nxt.mode.cm_level_high = PINS_IN.bandgap_out_or_level_select;
        // R18 coupling select, high means dc coupled
        s_nxt.mode.dc_coupled = PINS_IN.coupling_select;
        // R19 bias off when dc coupled
        s_nxt.mode.bias_enable = ~PINS_IN.coupling_select;
        // R16 offset only in extended mode
        s_nxt.mode.offset_enable = ext_mode;
    end

    // =================================================================
    // state register
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            s_r <= '0;
            s_r.state <= ST_POR_WAIT;
            s_r.hready <= 1'b1;
            s_r.range_i <= `RANGE_RESET_VAL;
            s_r.range_q <= `RANGE_RESET_VAL;
            s_r.por_armed <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // =================================================================
    // outputs
    assign TRIM_IN_PROGRESS_OUT = s_r.trim_run;
    assign MODE_OUT             = s_r.mode;
    assign OFFSET_OUT           = s_r.mode.offset_enable ? s_r.offset : `OFFSET_RESET_VAL;
    assign HREADYOUT_OUT        = s_r.hready;
    assign HRESP_OUT            = 1'b0;
    assign HRDATA_OUT           = s_r.rdata;
endmodule
`default_nettype wire

// ==== design/pin_mode_cfg.svh ====
/*
 * constants for the pin-mode decode and trim-start control block.
 * assumes a 40 MHz clock and pins already synchronous to it.
 */
`ifndef PIN_MODE_CFG_SVH
`define PIN_MODE_CFG_SVH
// =====================================================================
// register map: word index, byte address is four times the index
`define REG_CONTROL_IDX     6'h00
`define REG_RANGE_I_IDX     6'h03
`define REG_RANGE_Q_IDX     6'h0b
`define REG_STATUS_IDX      6'h10
`define REG_OFFSET_IDX      6'h11
`define REG_CONTROL_ADDR    {`REG_CONTROL_IDX, 2'b00}
`define REG_RANGE_I_ADDR    {`REG_RANGE_I_IDX, 2'b00}
`define REG_RANGE_Q_ADDR    {`REG_RANGE_Q_IDX, 2'b00}
`define REG_STATUS_ADDR     {`REG_STATUS_IDX, 2'b00}
`define REG_OFFSET_ADDR     {`REG_OFFSET_IDX, 2'b00}
// =====================================================================
// control register fields
`define CTL_TRIM_BIT        15
`define CTL_PHASE_BIT       14
`define CTL_INTERLEAVE_BIT  7
`define CTL_SECOND_IN_BIT   6
`define CTL_RESET_VAL       32'h0000_0000
// =====================================================================
// range codes and reset values
`define RANGE_MIN           2'h0
`define RANGE_MID           2'h1
`define RANGE_RESET_VAL     2'h1
`define OFFSET_RESET_VAL    13'h0000
// =====================================================================
// timing
`define CLK_PERIOD_NS       25
`define PIN_LOW_MIN_NS      1000
`define PIN_HIGH_MIN_NS     1000
`define POR_SHORT_NS        10000
`define POR_LONG_NS         1000000
`define TRIM_RUN_NS         50000
`define CYC_RNDUP(ns)       (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== design/pin_mode_pkg.sv ====
/*
 * types shared by the pin-mode control block.
 * assumes the cfg header holds all numbers.
 */
package pin_mode_pkg;
    typedef struct packed {
        logic trim_request;
        logic trim_start_delay_select;
        logic output_clock_phase_select;
        logic interleave_select;
        logic extended_control_enable_n;
        logic input_range_select;
        logic bandgap_out_or_level_select;
        logic coupling_select;
        logic unsplit_output_select;
    } pins_t;

    typedef struct packed {
        logic       interleaved;
        logic       convert_quadrature;
        logic       phase_90;
        logic       unsplit_output;
        logic [1:0] range_i;
        logic [1:0] range_q;
        logic       cm_level_high;
        logic       dc_coupled;
        logic       bias_enable;
        logic       offset_enable;
    } mode_t;

    typedef enum logic [1:0] {
        ST_POR_WAIT = 2'b00,
        ST_IDLE     = 2'b01,
        ST_RUN      = 2'b10
    } trim_state_t;

    typedef struct packed {
        trim_state_t state;
        logic [31:0] ctl;
        logic [1:0]  range_i;
        logic [1:0]  range_q;
        logic [12:0] offset;
        logic        por_armed;
        logic        req_prev;
        logic        seen_low;
        logic [15:0] low_cnt;
        logic [15:0] high_cnt;
        logic [15:0] wait_cnt;
        logic [15:0] run_cnt;
        logic        inhibit;
        logic        hready;
        logic        dp_active;
        logic        dp_write;
        logic [7:0]  dp_addr;
        logic [31:0] rdata;
        mode_t       mode;
        logic        trim_run;
        logic [15:0] trim_count;
    } state_t;
endpackage

// ==== verif/pin_mode_properties.sv ====
/*
 * port checker for the pin-mode control block.
 * assumes a bind onto pin_mode_control, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pin_mode_cfg.svh"
module pin_mode_properties #(
    parameter int RUN_CYC = `CYC_RNDUP(`TRIM_RUN_NS)
) (
    // clock and reset
    input  wire logic                CLOCK_IN,
    input  wire logic                SYS_RST_IN,
    // watched ports
    input  wire pin_mode_pkg::pins_t PINS_IN,
    input  wire logic                TRIM_IN_PROGRESS_OUT,
    input  wire pin_mode_pkg::mode_t MODE_OUT,
    input  wire logic [12:0]         OFFSET_OUT,
    input  wire logic                HREADYOUT_OUT,
    input  wire logic                HRESP_OUT
);
    import pin_mode_pkg::*;
    wire ext_off = PINS_IN.extended_control_enable_n;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // =========================================================
    // trim run: rises, stands at least eight cycles, and lasts RUN_CYC cycles when it drops
    sequence s_rise; $rose(TRIM_IN_PROGRESS_OUT); endsequence
    sequence s_run; TRIM_IN_PROGRESS_OUT [*8]; endsequence
    // run length counted while the flag stands, too long for a repetition
    int run_len;
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN)
            run_len <= 0;
        else
            run_len <= TRIM_IN_PROGRESS_OUT ? run_len + 1 : 0;
    end
    a_trim_hold: assert property (s_rise |-> s_run)
        else $error("trim run dropped early");
    a_trim_len: assert property ($fell(TRIM_IN_PROGRESS_OUT) |-> run_len == RUN_CYC)
        else $error("trim run length wrong");
    // =========================================================
    // pin decode, one cycle behind the pins, then bus always ready and okay
    a_bias_off: assert property (MODE_OUT.dc_coupled |-> !MODE_OUT.bias_enable)
        else $error("bias on in dc mode");
    a_phase_unsplit: assert property (MODE_OUT.unsplit_output |-> !MODE_OUT.phase_90)
        else $error("phase set in 1:1 mode");
    a_coupling_follow: assert property (1'b1 |=> MODE_OUT.dc_coupled == $past(PINS_IN.coupling_select))
        else $error("coupling decode wrong");
    a_level_follow: assert property (1'b1 |=> MODE_OUT.cm_level_high == $past(PINS_IN.bandgap_out_or_level_select))
        else $error("level decode wrong");
    a_unsplit_follow: assert property (1'b1 |=> MODE_OUT.unsplit_output == $past(PINS_IN.unsplit_output_select))
        else $error("unsplit decode wrong");
    a_offset_gate: assert property (ext_off |=> OFFSET_OUT == 13'h0000 && !MODE_OUT.offset_enable)
        else $error("offset active outside extended mode");
    a_pin_interleave: assert property (ext_off |=> MODE_OUT.interleaved == $past(PINS_IN.interleave_select))
        else $error("interleave pin decode wrong");
    a_pin_range: assert property (ext_off |=> MODE_OUT.range_i == {1'b0, $past(PINS_IN.input_range_select)}
        && MODE_OUT.range_q == MODE_OUT.range_i) else $error("range pin decode wrong");
    a_pin_phase: assert property (ext_off && !PINS_IN.unsplit_output_select
        |=> MODE_OUT.phase_90 == $past(PINS_IN.output_clock_phase_select)) else $error("phase pin decode wrong");
    a_ready_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
        else $error("bus not ready or not okay");
endmodule
`default_nettype wire

// ==== verif/host_pins.sv ====
/*
 * host model driving the control pins.
 * assumes the bench sets static levels and asks for trim pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module host_pins (
    // clock
    input  wire logic                clk_in,
    // requested levels and trim pulse
    input  wire pin_mode_pkg::pins_t cfg_in,
    input  wire logic                pulse_in,
    // pins
    output var  pin_mode_pkg::pins_t pins_out
);
    import pin_mode_pkg::*;
    // hold is past the minimum low and high times
    localparam int HOLD = 45;
    int cnt_r = 0;
    // =========================================================
    // request low, then high, each held past minimum
    always @(posedge clk_in) begin
        if (pulse_in)
            cnt_r <= 2 * HOLD;
        else if (cnt_r != 0)
            cnt_r <= cnt_r - 1;
    end
    always_comb begin
        pins_out = cfg_in;
        if (cnt_r > HOLD)
            pins_out.trim_request = 1'b0;
        else if (cnt_r != 0)
            pins_out.trim_request = 1'b1;
    end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
/*
 * self-checking bench for pin_mode_control.
 * assumes shortened power-on and run counts, zero-wait bus slave.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pin_mode_pkg::*;
    localparam int POR_S = 20;
    localparam int POR_L = 40;
    localparam int RUN   = 10;
    logic        CLOCK_IN = 1'b0, SYS_RST_IN = 1'b1, HSEL_IN = 1'b0, HWRITE_IN = 1'b0, pulse = 1'b0;
    logic [1:0]  HTRANS_IN = 2'h0;
    logic [31:0] HADDR_IN = 32'h0, HWDATA_IN = 32'h0, HRDATA_OUT, rd;
    logic        HREADYOUT_OUT, HRESP_OUT, TRIM_IN_PROGRESS_OUT;
    logic [12:0] OFFSET_OUT;
    pins_t       cfg = '0, pins;
    mode_t       MODE_OUT, em;
    int          n_fail = 0, checks = 0, dly, len;
    initial begin
        forever #12.5 CLOCK_IN = ~CLOCK_IN;
    end
    host_pins PART (.clk_in(CLOCK_IN), .cfg_in(cfg), .pulse_in(pulse), .pins_out(pins));
    pin_mode_control #(.POR_SHORT_CYC(POR_S), .POR_LONG_CYC(POR_L), .TRIM_RUN_CYC(RUN)) DUT (
        .CLOCK_IN(CLOCK_IN), .SYS_RST_IN(SYS_RST_IN), .PINS_IN(pins), .TRIM_IN_PROGRESS_OUT(TRIM_IN_PROGRESS_OUT),
        .MODE_OUT(MODE_OUT), .OFFSET_OUT(OFFSET_OUT), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
        .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HSIZE_IN(3'h2), .HWDATA_IN(HWDATA_IN),
        .HREADY_IN(HREADYOUT_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .HRDATA_OUT(HRDATA_OUT));
    // =========================================================
    // tasks
    task automatic chk(input string n, input logic [31:0] e, s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // values are taken at the negedge before the sampling edge
    task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        logic rdy;
        @(posedge CLOCK_IN);
        HSEL_IN <= 1'b1;
        HTRANS_IN <= 2'h2;
        HWRITE_IN <= w;
        HADDR_IN <= a;
        do begin
            @(negedge CLOCK_IN);
            rdy = HREADYOUT_OUT;
            @(posedge CLOCK_IN);
        end while (rdy !== 1'b1);
        HSEL_IN <= 1'b0;
        HTRANS_IN <= 2'h0;
        HWDATA_IN <= d;
        do begin
            @(negedge CLOCK_IN);
            rdy = HREADYOUT_OUT;
            r = HRDATA_OUT;
            @(posedge CLOCK_IN);
        end while (rdy !== 1'b1);
    endtask
    task automatic rst(input logic dsel, rq);
        @(posedge CLOCK_IN);
        SYS_RST_IN <= 1'b1;
        cfg.trim_start_delay_select <= dsel;
        cfg.trim_request <= rq;
        repeat (2) @(posedge CLOCK_IN);
        SYS_RST_IN <= 1'b0;
    endtask
    task automatic meas;
        dly = 0;
        len = 0;
        while (TRIM_IN_PROGRESS_OUT !== 1'b1 && dly < 300) begin
            @(negedge CLOCK_IN);
            dly++;
        end
        while (TRIM_IN_PROGRESS_OUT === 1'b1 && len < 300) begin
            @(negedge CLOCK_IN);
            len++;
        end
    endtask
    task automatic final_report;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // =========================================================
    // tests
    initial begin
        rst(1'b0, 1'b0);
        meas;
        chk("por short", 1, dly inside {[POR_S:POR_S+6]});
        chk("run len", RUN, len);
        for (int i = 0; i < 4; i++) begin
            @(posedge CLOCK_IN);
            cfg <= '{1'b0, 1'b0, i[0], i[1], 1'b1, i[0], i[1], i[0], i[1]};
            repeat (3) @(negedge CLOCK_IN);
            em = '{i[1], 1'b0, i[0] & ~i[1], i[1], {1'b0, i[0]}, {1'b0, i[0]}, i[1], i[0], ~i[0], 1'b0};
            chk("mode pins", em, MODE_OUT);
        end
        @(posedge CLOCK_IN);
        cfg <= '0;
        ahb(1'b1, 32'h00, 32'h0000_40c0, rd);
        ahb(1'b1, 32'h0c, 32'h0, rd);
        ahb(1'b1, 32'h44, 32'h0000_0123, rd);
        ahb(1'b0, 32'h2c, 32'h0, rd);
        chk("range q", 1, rd);
        ahb(1'b0, 32'h00, 32'h0, rd);
        chk("control", 32'h0000_40c0, rd);
        ahb(1'b0, 32'h80, 32'h0, rd);
        chk("unmapped", 0, rd);
        @(negedge CLOCK_IN);
        chk("mode ext", 8'hf1, {MODE_OUT.phase_90, MODE_OUT.interleaved, MODE_OUT.convert_quadrature,
            MODE_OUT.offset_enable, MODE_OUT.range_i, MODE_OUT.range_q});
        chk("offset", 32'h123, OFFSET_OUT);
        repeat (45) @(posedge CLOCK_IN);
        ahb(1'b1, 32'h00, 32'h0000_c0c0, rd);
        meas;
        chk("bit trim", 1, dly inside {[36:48]});
        chk("bit run len", RUN, len);
        ahb(1'b0, 32'h40, 32'h0, rd);
        chk("status", 32'h0002_0002, rd);
        @(posedge CLOCK_IN);
        cfg.extended_control_enable_n <= 1'b1;
        repeat (3) @(posedge CLOCK_IN);
        ahb(1'b0, 32'h00, 32'h0, rd);
        chk("control default", 0, rd);
        @(negedge CLOCK_IN);
        chk("offset off", 0, OFFSET_OUT);
        rst(1'b1, 1'b0);
        meas;
        chk("por long", 1, dly inside {[POR_L:POR_L+6]});
        rst(1'b0, 1'b1);
        meas;
        chk("por inhibit", 300, dly);
        ahb(1'b0, 32'h40, 32'h0, rd);
        chk("status inhibit", 32'h0000_0004, rd);
        @(posedge CLOCK_IN);
        pulse <= 1'b1;
        @(posedge CLOCK_IN);
        pulse <= 1'b0;
        meas;
        chk("pin trim", 1, dly inside {[80:96]});
        final_report;
    end
    initial begin
        #100000;
        n_fail++;
        final_report;
    end
endmodule
bind pin_mode_control pin_mode_properties #(.RUN_CYC(TRIM_RUN_CYC)) u_props (.CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN), .PINS_IN(PINS_IN),
    .TRIM_IN_PROGRESS_OUT(TRIM_IN_PROGRESS_OUT), .MODE_OUT(MODE_OUT), .OFFSET_OUT(OFFSET_OUT),
    .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT));
`default_nettype wire
